// ==== rtl/dcr_defines.svh ====
// Register map, field positions and reset values for the converter control block.
// Assumes a 32-bit AXI4-Lite slave with one aligned word per register.
`ifndef DCR_DEFINES_SVH
`define DCR_DEFINES_SVH

// Register indices; byte address is four times the index
`define DCR_IDX_LEVEL_FIRST 12'h07D
`define DCR_IDX_CTRL_FIRST 12'h07F
`define DCR_IDX_LEVEL_SECOND 12'h0A0
`define DCR_IDX_CTRL_SECOND 12'h0A2
`define DCR_ADDR_LEVEL_FIRST (`DCR_IDX_LEVEL_FIRST * 12'h004)
`define DCR_ADDR_CTRL_FIRST (`DCR_IDX_CTRL_FIRST * 12'h004)
`define DCR_ADDR_LEVEL_SECOND (`DCR_IDX_LEVEL_SECOND * 12'h004)
`define DCR_ADDR_CTRL_SECOND (`DCR_IDX_CTRL_SECOND * 12'h004)

// Control field positions
`define DCR_BIT_EN 7
`define DCR_OE_HI 5
`define DCR_OE_LO 4
`define DCR_PSS_HI 3
`define DCR_PSS_LO 2
`define DCR_BIT_NSS 0

// Implemented bits of each control register
`define DCR_MASK_CTRL_FIRST 8'hBD
`define DCR_MASK_CTRL_SECOND 8'h8D

// Reset values
`define DCR_RST_CTRL 8'h00
`define DCR_RST_LEVEL 8'h00

// Field encodings
`define DCR_OE_SECOND_PIN 2'h2
`define DCR_OE_FIRST_PIN 2'h1
`define DCR_PSS_SUPPLY 2'h0
`define DCR_PSS_EXT 2'h1
`define DCR_PSS_FIXED 2'h2

// AXI responses
`define DCR_RESP_OKAY 2'h0
`define DCR_RESP_SLVERR 2'h2

`endif

// ==== rtl/dcr_pkg.sv ====
// Types shared by the converter control block and its users.
// Assumes the constants header alongside for all numeric values.
package dcr_pkg;

	// Settings presented to one converter's ladder and reference muxes
	typedef struct packed {
		logic power;          // Converter powered
		logic ref_on;         // Reference ladder energised
		logic [2:0] pos_sel;  // One-hot: fixed_reference, external, supply
		logic neg_ext;        // 1: external negative ref, 0: ground
		logic [7:0] level_code;
	} dcr_conv_type;

	// Pin routing of the buffered instance
	typedef struct packed {
		logic second_output_pin_oe;
		logic first_output_pin_oe;
	} dcr_pins_type;

endpackage : dcr_pkg

// ==== rtl/dcr_top.sv ====
// Control registers for two 8-bit ladder converters behind an AXI4-Lite slave.
// Assumes a synchronous active-low reset and an analog ladder and mux that
// follow the settings presented here without further handshaking.
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "dcr_defines.svh"

module dcr_top #(
	parameter int ADDR_WIDTH = 12,
	parameter int CODE_WIDTH = 8
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address and data
	input wire logic [ADDR_WIDTH-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// AXI4-Lite write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read
	input wire logic [ADDR_WIDTH-1:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Device power state
	input wire logic sleep_mode,
	// Analog side
	output dcr_pkg::dcr_conv_type buffered_instance,
	output dcr_pkg::dcr_conv_type internal_instance,
	output dcr_pkg::dcr_pins_type analog_output_pin,
	output logic [(1<<CODE_WIDTH)-1:0] buffered_tap,
	output logic [(1<<CODE_WIDTH)-1:0] internal_tap
);
	import dcr_pkg::*;

	localparam int LEVELS = 1 << CODE_WIDTH;

	// Register contents
	logic [7:0] control_first;
	logic [7:0] control_second;
	logic [CODE_WIDTH-1:0] level_code_first;
	logic [CODE_WIDTH-1:0] level_code_second;

	// Write channel holding state; address and data may arrive in either order
	logic aw_held;
	logic w_held;
	logic [ADDR_WIDTH-1:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;

	// Handshake readies are combinational off holding state
	assign awready = !aw_held && !bvalid;
	assign wready = !w_held && !bvalid;
	assign arready = !rvalid;

	// Write decode; protection bits are accepted but not checked
	wire do_write = aw_held && w_held && !bvalid;
	wire wr_lane0 = do_write && w_strb_q[0];
	wire [7:0] wr_byte = w_data_q[7:0];
	wire wr_hit_ctrl_first = (aw_addr_q == ADDR_WIDTH'(`DCR_ADDR_CTRL_FIRST));
	wire wr_hit_level_first = (aw_addr_q == ADDR_WIDTH'(`DCR_ADDR_LEVEL_FIRST));
	wire wr_hit_ctrl_second = (aw_addr_q == ADDR_WIDTH'(`DCR_ADDR_CTRL_SECOND));
	wire wr_hit_level_second = (aw_addr_q == ADDR_WIDTH'(`DCR_ADDR_LEVEL_SECOND));
	wire wr_hit = wr_hit_ctrl_first || wr_hit_level_first || wr_hit_ctrl_second
		|| wr_hit_level_second;

	// Holding registers for the write address and data
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			aw_addr_q <= '0;
		end else if (awvalid && awready) begin
			aw_held <= 1'b1;
			aw_addr_q <= awaddr;
		end else if (do_write) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held <= 1'b0;
			w_data_q <= '0;
			w_strb_q <= '0;
		end else if (wvalid && wready) begin
			w_held <= 1'b1;
			w_data_q <= wdata;
			w_strb_q <= wstrb;
		end else if (do_write) begin
			w_held <= 1'b0;
		end
	end

	// Write response is raised on the same edge as the register update
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp <= `DCR_RESP_OKAY;
		end else if (do_write) begin
			bvalid <= 1'b1;
			bresp <= wr_hit ? `DCR_RESP_OKAY : `DCR_RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// only aresetn and bus writes touch them, sleep never does
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			control_first <= `DCR_RST_CTRL;
			control_second <= `DCR_RST_CTRL;
			level_code_first <= CODE_WIDTH'(`DCR_RST_LEVEL);
			level_code_second <= CODE_WIDTH'(`DCR_RST_LEVEL);
		end else begin
			if (wr_lane0 && wr_hit_ctrl_first)
				control_first <= wr_byte & `DCR_MASK_CTRL_FIRST;
			if (wr_lane0 && wr_hit_ctrl_second)
				control_second <= wr_byte & `DCR_MASK_CTRL_SECOND;
			if (wr_lane0 && wr_hit_level_first)
				level_code_first <= wr_byte[CODE_WIDTH-1:0];
			if (wr_lane0 && wr_hit_level_second)
				level_code_second <= wr_byte[CODE_WIDTH-1:0];
		end
	end

	// Read decode and data selection
	wire rd_hit_ctrl_first = (araddr == ADDR_WIDTH'(`DCR_ADDR_CTRL_FIRST));
	wire rd_hit_level_first = (araddr == ADDR_WIDTH'(`DCR_ADDR_LEVEL_FIRST));
	wire rd_hit_ctrl_second = (araddr == ADDR_WIDTH'(`DCR_ADDR_CTRL_SECOND));
	wire rd_hit_level_second = (araddr == ADDR_WIDTH'(`DCR_ADDR_LEVEL_SECOND));
	wire rd_hit = rd_hit_ctrl_first || rd_hit_level_first || rd_hit_ctrl_second
		|| rd_hit_level_second;
	wire [7:0] rd_byte = rd_hit_ctrl_first ? control_first :
		rd_hit_ctrl_second ? control_second :
		rd_hit_level_first ? 8'(level_code_first) :
		rd_hit_level_second ? 8'(level_code_second) : 8'h00;

	// Read answer registered on the same edge that takes the address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= `DCR_RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rdata <= {24'h000000, rd_byte};
			rresp <= rd_hit ? `DCR_RESP_OKAY : `DCR_RESP_SLVERR;
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end

	wire en_first = control_first[`DCR_BIT_EN];
	wire en_second = control_second[`DCR_BIT_EN];
	// sleep overrides the enable for the reference
	wire ref_first = en_first && !sleep_mode;
	wire ref_second = en_second && !sleep_mode;

	// positive reference; reserved code selects nothing
	function automatic logic [2:0] pos_decode(input logic [1:0] positive_ref_select);
		logic [2:0] sel;
		sel = 3'h0;
		case (positive_ref_select)
			`DCR_PSS_SUPPLY: sel = 3'h1;
			`DCR_PSS_EXT: sel = 3'h2;
			`DCR_PSS_FIXED: sel = 3'h4;
			default: sel = 3'h0;
		endcase
		return sel;
	endfunction : pos_decode

	// Converter settings; the mux settings stay registered so they are ready at wake
	// negative reference select
	assign buffered_instance.power = en_first;
	assign buffered_instance.ref_on = ref_first;
	assign buffered_instance.pos_sel = pos_decode(control_first[`DCR_PSS_HI:`DCR_PSS_LO]);
	assign buffered_instance.neg_ext = control_first[`DCR_BIT_NSS];
	assign buffered_instance.level_code = 8'(level_code_first);
	assign internal_instance.power = en_second;
	assign internal_instance.ref_on = ref_second;
	assign internal_instance.pos_sel = pos_decode(control_second[`DCR_PSS_HI:`DCR_PSS_LO]);
	assign internal_instance.neg_ext = control_second[`DCR_BIT_NSS];
	assign internal_instance.level_code = 8'(level_code_second);

	// pin routing from the select field
	// codes 00 and 11 drive neither pin; a disabled converter drives none
	wire [1:0] oe_field = control_first[`DCR_OE_HI:`DCR_OE_LO];
	assign analog_output_pin.first_output_pin_oe = en_first && (oe_field == `DCR_OE_FIRST_PIN);
	assign analog_output_pin.second_output_pin_oe =
		en_first && (oe_field == `DCR_OE_SECOND_PIN);
	// the second instance has no pin logic at all

	// one ladder tap per code, taps dead while the reference is off
	genvar tap_i;
	generate
		for (tap_i = 0; tap_i < LEVELS; tap_i++) begin : g_tap
			assign buffered_tap[tap_i] = ref_first
				&& (level_code_first == CODE_WIDTH'(tap_i));
			assign internal_tap[tap_i] = ref_second
				&& (level_code_second == CODE_WIDTH'(tap_i));
		end
	endgenerate

	// Checks on the block's own behaviour
	property p_enable_power;
		@(posedge aclk) disable iff (!aresetn)
		do_write && w_strb_q[0] && wr_hit_ctrl_first |=>
			buffered_instance.power == $past(w_data_q[7]);
	endproperty
	a_enable_power: assert property (p_enable_power)
		else $error("enable write did not reach converter power");

	property p_pin_route;
		@(posedge aclk) disable iff (!aresetn)
		buffered_instance.power && control_first[5:4] == 2'h2 |->
			analog_output_pin.second_output_pin_oe && !analog_output_pin.first_output_pin_oe;
	endproperty
	a_pin_route: assert property (p_pin_route)
		else $error("select code 10 did not route to second pin");

	property p_one_hot_pins;
		@(posedge aclk) disable iff (!aresetn)
		!(analog_output_pin.first_output_pin_oe && analog_output_pin.second_output_pin_oe);
	endproperty
	a_one_hot_pins: assert property (p_one_hot_pins)
		else $error("both output pins driven");

	property p_pos_ref;
		@(posedge aclk) disable iff (!aresetn)
		control_second[3:2] == 2'h2 |-> internal_instance.pos_sel == 3'h4;
	endproperty
	a_pos_ref: assert property (p_pos_ref)
		else $error("fixed reference not selected for code 10");

	property p_neg_ref;
		@(posedge aclk) disable iff (!aresetn)
		do_write && w_strb_q[0] && wr_hit_ctrl_second |=>
			internal_instance.neg_ext == $past(w_data_q[0]);
	endproperty
	a_neg_ref: assert property (p_neg_ref)
		else $error("negative reference select not stored");

	property p_level_store;
		@(posedge aclk) disable iff (!aresetn)
		do_write && w_strb_q[0] && wr_hit_level_first |=> bvalid
			&& buffered_instance.level_code == $past(w_data_q[7:0]);
	endproperty
	a_level_store: assert property (p_level_store)
		else $error("level code write lost");

	property p_tap_count;
		@(posedge aclk) disable iff (!aresetn)
		$countones(internal_tap) == (internal_instance.ref_on ? 1 : 0);
	endproperty
	a_tap_count: assert property (p_tap_count)
		else $error("ladder tap selection not one-hot");

	property p_reset_state;
		@(posedge aclk)
		!aresetn |=> !buffered_instance.power && analog_output_pin == 2'h0
			&& buffered_instance.level_code == 8'h00 && internal_instance.level_code == 8'h00;
	endproperty
	a_reset_state: assert property (p_reset_state)
		else $error("reset left converter active or code set");

	property p_sleep_keep;
		@(posedge aclk) disable iff (!aresetn)
		sleep_mode && !do_write |=> $stable(control_first) && $stable(control_second)
			&& $stable(level_code_first) && $stable(level_code_second);
	endproperty
	a_sleep_keep: assert property (p_sleep_keep)
		else $error("register changed during sleep without a write");

	property p_sleep_ref_off;
		@(posedge aclk) disable iff (!aresetn)
		sleep_mode |-> !buffered_instance.ref_on && !internal_instance.ref_on;
	endproperty
	a_sleep_ref_off: assert property (p_sleep_ref_off)
		else $error("reference on during sleep");

	property p_read_mask;
		@(posedge aclk) disable iff (!aresetn)
		arvalid && arready && rd_hit_ctrl_second |=>
			rvalid && (rdata & 32'hFFFFFF72) == 32'h00000000;
	endproperty
	a_read_mask: assert property (p_read_mask)
		else $error("unimplemented control bits read nonzero");

	property p_second_addr;
		@(posedge aclk) disable iff (!aresetn)
		arvalid && arready && araddr == ADDR_WIDTH'(12'h280) |=>
			rresp == 2'h0 && rdata[7:0] == 8'($past(level_code_second));
	endproperty
	a_second_addr: assert property (p_second_addr)
		else $error("second level register not at its address");

	// Read data is the value held before the answering edge
	property p_first_addr;
		@(posedge aclk) disable iff (!aresetn)
		arvalid && arready && araddr == ADDR_WIDTH'(12'h1FC) |=>
			rresp == `DCR_RESP_OKAY && rdata[7:0] == $past(control_first);
	endproperty
	a_first_addr: assert property (p_first_addr)
		else $error("first control register not at its address");

	property p_pin_first;
		@(posedge aclk) disable iff (!aresetn)
		buffered_instance.power && oe_field == `DCR_OE_FIRST_PIN |->
			analog_output_pin.first_output_pin_oe && !analog_output_pin.second_output_pin_oe;
	endproperty
	a_pin_first: assert property (p_pin_first)
		else $error("select code 01 did not route to first pin");

	// Codes 00 and 11, or a disabled converter, leave both pins free
	property p_pin_none;
		@(posedge aclk) disable iff (!aresetn)
		!buffered_instance.power || oe_field[1] == oe_field[0] |-> analog_output_pin == 2'h0;
	endproperty
	a_pin_none: assert property (p_pin_none)
		else $error("output pin driven while deselected or disabled");

endmodule : dcr_top

// ==== dv/dcr_ladder_model.sv ====
// Behavioural stand-in for one resistor ladder and its reference muxes.
// Assumes a one-hot tap vector from the control block, all zero when dark.
`timescale 1ns/1ps
module dcr_ladder_model (
	// Settings from the control block
	input wire dcr_pkg::dcr_conv_type conv,
	input wire logic [255:0] tap,
	// Observed ladder state
	output logic [7:0] level_seen,
	output logic [8:0] tap_count,
	output logic lit_dark
);
	import dcr_pkg::*;

	always_comb begin
		level_seen = 8'h00;
		tap_count = 9'h000;
		for (int i = 0; i < 256; i++) begin
			if (tap[i] === 1'b1) begin
				level_seen = i[7:0];
				tap_count = tap_count + 9'h001;
			end
		end
		// A lit tap with the reference off means current drawn in sleep
		lit_dark = (tap_count != 9'h000) && !conv.ref_on;
	end
endmodule : dcr_ladder_model

// ==== dv/testbench.sv ====
// Self-checking bench for the converter control registers.
// Assumes the ladder model beside it and a 40 MHz register clock.
`timescale 1ns/1ps
`include "dcr_defines.svh"
module testbench;
	import dcr_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic sleep_mode = 1'b0;
	logic [31:0] wdata = 32'h0, rdata;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	dcr_conv_type buffered_instance, internal_instance;
	dcr_pins_type analog_output_pin;
	logic [255:0] buffered_tap, internal_tap;
	logic [7:0] level_seen;
	logic [8:0] tap_count;
	logic lit_dark;
	logic [7:0] shadow [4];
	logic [11:0] addr_tab [4] = '{`DCR_ADDR_LEVEL_FIRST, `DCR_ADDR_CTRL_FIRST,
		`DCR_ADDR_LEVEL_SECOND, `DCR_ADDR_CTRL_SECOND};
	logic [7:0] mask_tab [4] = '{8'hFF, 8'hBD, 8'hFF, 8'h8D};
	int fail_count = 0;
	int samples_checked = 0;

	// Register clock
	always #12.5 aclk = ~aclk;

	dcr_top dcr_top_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .sleep_mode(sleep_mode),
		.buffered_instance(buffered_instance), .internal_instance(internal_instance),
		.analog_output_pin(analog_output_pin), .buffered_tap(buffered_tap),
		.internal_tap(internal_tap));

	dcr_ladder_model dcr_ladder_model_i (.conv(buffered_instance), .tap(buffered_tap),
		.level_seen(level_seen), .tap_count(tap_count), .lit_dark(lit_dark));

	task automatic check(input logic [255:0] seen, input logic [255:0] exp, input string msg);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask : check

	// Both channels offered together; each dropped once taken
	// No local limit: only the watchdog ends a hung wait
	task automatic bus_write(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
		bit got;
		int n;
		got = 1'b0;
		n = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!got) begin
			@(posedge aclk);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) begin
				r = bresp;
				got = 1'b1;
			end
		end
		bready <= 1'b0;
		check(n, 3, "write latency");
	endtask : bus_write

	task automatic bus_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		bit got;
		int n;
		got = 1'b0;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!got) begin
			@(posedge aclk);
			n++;
			if (arready) arvalid <= 1'b0;
			if (rvalid) begin
				d = rdata;
				r = rresp;
				got = 1'b1;
			end
		end
		rready <= 1'b0;
		check(n, 2, "read latency");
	endtask : bus_read

	function automatic logic [13:0] exp_conv(input logic [7:0] c, input logic [7:0] l);
		logic [2:0] p;
		p = (c[3:2] == 2'h0) ? 3'h1 : (c[3:2] == 2'h1) ? 3'h2 : (c[3:2] == 2'h2) ? 3'h4 : 3'h0;
		return {c[7], c[7] & ~sleep_mode, p, c[0], l};
	endfunction : exp_conv

	// Outputs must follow the shadow copy of the registers
	task automatic check_outputs();
		logic [7:0] c1;
		logic on;
		c1 = shadow[1];
		on = c1[7] & ~sleep_mode;
		check(buffered_instance, exp_conv(c1, shadow[0]), "buffered settings");
		check(internal_instance, exp_conv(shadow[3], shadow[2]), "internal settings");
		check(analog_output_pin, {c1[7] & (c1[5:4] == 2'h2), c1[7] & (c1[5:4] == 2'h1)},
			"pin enables");
		check(&analog_output_pin, 1'b0, "two pins driven");
		check(tap_count, on, "active taps");
		check(level_seen, on ? shadow[0] : 8'h00, "ladder level");
		check(internal_tap, (shadow[3][7] & ~sleep_mode) ? (256'h1 << shadow[2]) : 256'h0,
			"internal tap");
		check(lit_dark, 1'b0, "ladder lit without reference");
	endtask : check_outputs

	task automatic check_regs();
		logic [31:0] d;
		logic [1:0] r;
		for (int k = 0; k < 4; k++) begin
			bus_read(addr_tab[k], d, r);
			check(d, shadow[k], "register readback");
			check(r, `DCR_RESP_OKAY, "read response");
		end
	endtask : check_regs

	task automatic do_write(input int k, input logic [7:0] d);
		logic [1:0] r;
		bus_write(addr_tab[k], d, r);
		check(r, `DCR_RESP_OKAY, "write response");
		shadow[k] = d & mask_tab[k];
		check_outputs();
		check_regs();
	endtask : do_write

	task automatic end_sim();
		$display("checked %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_sim

	// Hang guard, well past the expected run length
	initial begin
		repeat (40000) @(posedge aclk);
		fail_count++;
		end_sim();
	end

	initial begin
		logic [7:0] d;
		logic [31:0] q;
		logic [1:0] r;
		int k;
		void'($urandom(29284));
		foreach (shadow[j]) shadow[j] = 8'h00;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		check_outputs();
		check_regs();
		$display("test reset_values done");
		// Every pin code and reference codes 00 to 10, unimplemented bits set
		for (int i = 0; i < 16; i++) begin
			d = {2'b11, i[3:0], 2'b11};
			if (i[1:0] != 2'h3) do_write(1, d);
			if (i[1:0] != 2'h3) do_write(3, d);
		end
		$display("test code_table done");
		repeat (150) begin
			k = $urandom % 4;
			d = $urandom;
			if (k[0] && d[3:2] == 2'h3) d[3] = 1'b0;
			sleep_mode <= $urandom % 2;
			do_write(k, d);
		end
		$display("test random done");
		bus_write(12'h1F8, 8'h5A, r);
		check(r, `DCR_RESP_SLVERR, "unmapped write");
		bus_read(12'h1F8, q, r);
		check({r, q}, {`DCR_RESP_SLVERR, 32'h0}, "unmapped read");
		check_regs();
		$display("test unmapped done");
		do_write(1, 8'h91);
		sleep_mode <= 1'b1;
		repeat (3) @(posedge aclk);
		check_outputs();
		sleep_mode <= 1'b0;
		check_regs();
		$display("test sleep done");
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		foreach (shadow[j]) shadow[j] = 8'h00;
		check_outputs();
		check_regs();
		$display("test mid_reset done");
		end_sim();
	end
endmodule : testbench
